/* design/vpi_pkg.sv */
// constants, states and carriers for the virtual fabric port init machine
// assumes a single pclk domain and an apb master for configuration
// Summary of operation
// R1: link parameter state sends request with default-fabric element name.
// R2: untagged operation keeps using default-fabric element name.
// R3: each port holds tagging admin status, default fabric id, enable list.
// R4: esc request advertises fabric support; reply selects it to negotiate.
// R5: behind a bridge, no fabric support unless bridge tagging flag is one.
// R6: if either side lacks support, esc goes to untagged continuation.
// R7: link reset leaves tagging alone; link init returns to start state.
// R8: after esc, go evfp if no auth needed, else authentication state.
// R9: evfp request during authentication rejected logical busy, checks running.
// R10: auth failure goes to failure state; success goes to evfp.
// R11: no tagging: equal default ids continue untagged, else isolated.
// R12: tagging starts one per-fabric sub-machine per negotiated fabric.
// R13: per-fabric link params tagged with k, k's name, no flow setup; the code drives name_vfid from def_vfid_r for every fabric.
// R14: per-fabric link parameter done advances to security checks.
// R15: security checks tag k; efp before done rejected logical busy.
// R16: checks pass go operating; checks fail go logical isolation.
// R17: operating state tags k, joins configuration, uses k's name; the code drives name_vfid from def_vfid_r for every fabric.
// R18: isolation blocks class n traffic; any fabric protocol may force it.
// R19: isolated fabric returns to link parameters on link parameter request.
// R20: administrator setting disables the authentication step; the code still runs it when the peer requests auth.
// R21: fabric ids are twelve bits wide everywhere.
// R22: untagged received frames belong to the default fabric id.
// R23: per-fabric sub-machines advance independently of each other.
package vpi_pkg;
  localparam int VFID_W = 12;
  localparam int NUM_VF = 4;
  localparam logic [VFID_W-1:0] DEF_VFID_RST = 12'h001;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VFID = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_FAB0 = 8'h10;
  localparam int CTRL_TAG_ADMIN = 0;
  localparam int CTRL_AUTH_DIS = 1;
  localparam int CTRL_VF_CAP = 2;
  localparam int FAB_EN_BIT = 12;
  localparam logic [3:0] RJT_LOGICAL_BUSY = 4'h1;
  localparam logic [3:0] EXPL_SEC_CHECKS = 4'h2;

  typedef enum logic [3:0] {
    port_init_start_state, link_param_exchange_state, esc_exchange_state,
    vf_authentication_state, auth_failure_state, evfp_processing_state,
    untagged_continuation_state, untagged_eport_operating_state,
    isolated_state, tagging_active_state
  } vpi_main_type;

  typedef enum logic [2:0] {
    fab_idle_state, per_fabric_link_param_state,
    per_fabric_security_check_state, per_fabric_operating_state,
    per_fabric_logical_isolation_state
  } vpi_fab_type;

  typedef struct packed {
    logic link_init;
    logic link_reset;
    logic elp_done;
    logic bridge_peer;
    logic bridge_vf_flag;
    logic esc_done;
    logic peer_vf_sup;
    logic peer_auth_req;
    logic auth_ok;
    logic auth_fail;
    logic evfp_rx;
    logic evfp_done;
    logic evfp_tag;
    logic [VFID_W-1:0] peer_vfid;
    logic untag_done;
  } vpi_evt_type;

  typedef struct packed {
    logic [NUM_VF-1:0] elp_done;
    logic [NUM_VF-1:0] sec_ok;
    logic [NUM_VF-1:0] sec_fail;
    logic [NUM_VF-1:0] efp_rx;
    logic [NUM_VF-1:0] force_iso;
    logic [NUM_VF-1:0] elp_seen;
  } vpi_fab_evt_type;

  typedef struct packed {
    logic esc_adv_vf;
    logic use_default_name;
    logic [VFID_W-1:0] name_vfid;
    logic send_rjt;
    logic [3:0] rjt_reason;
    logic [3:0] rjt_expl;
    logic tag_rx_en;
  } vpi_act_type;
endpackage

/* design/vpi_port_init.sv */
// virtual fabric port init machine with per-fabric sub-machines
// assumes events from link logic are synchronous to pclk, one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module vpi_port_init #(
  parameter int NUM_VF = vpi_pkg::NUM_VF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vpi_pkg::vpi_evt_type evt,
  input wire vpi_pkg::vpi_fab_evt_type fevt,
  input wire logic [vpi_pkg::VFID_W-1:0] rx_vfid,
  input wire logic rx_tagged,
  output logic [vpi_pkg::VFID_W-1:0] rx_class_vfid,
  output vpi_pkg::vpi_act_type act,
  output logic [NUM_VF-1:0] fab_send_elp,
  output logic [NUM_VF-1:0] fab_tag_en,
  output logic [NUM_VF-1:0] fab_send_rjt,
  output logic [NUM_VF-1:0] fab_join_cfg,
  output logic [NUM_VF-1:0] fab_class_n_en,
  output vpi_pkg::vpi_main_type main_state
);
  import vpi_pkg::*;

  logic ctrl_tag_admin_r, ctrl_auth_dis_r, ctrl_vf_cap_r;
  logic [VFID_W-1:0] def_vfid_r;
  logic [VFID_W-1:0] fab_vfid_r [NUM_VF];
  logic [NUM_VF-1:0] fab_en_r;
  vpi_main_type st_r, st_nxt;
  vpi_fab_type fst_r [NUM_VF];
  logic wr, rd;
  logic vf_ok, neg_vf, auth_needed;

  // apb slave, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // per-port configuration
  always_ff @(posedge pclk or negedge presetn) begin // R3
    if (!presetn) begin
      ctrl_tag_admin_r <= 1'b0;
      ctrl_auth_dis_r <= 1'b0;
      ctrl_vf_cap_r <= 1'b0;
      def_vfid_r <= DEF_VFID_RST;
    end else if (wr) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_tag_admin_r <= pwdata[CTRL_TAG_ADMIN];
        ctrl_auth_dis_r <= pwdata[CTRL_AUTH_DIS]; // R20
        ctrl_vf_cap_r <= pwdata[CTRL_VF_CAP];
      end
      if (paddr == ADDR_VFID) begin
        def_vfid_r <= pwdata[VFID_W-1:0]; // R21
      end
    end
  end

  // locally enabled list, one word per slot
  for (genvar k = 0; k < NUM_VF; k++) begin : g_list
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fab_vfid_r[k] <= '0;
        fab_en_r[k] <= 1'b0;
      end else if (wr && paddr == ADDR_FAB0 + 8'(4 * k)) begin
        fab_vfid_r[k] <= pwdata[VFID_W-1:0]; // R3
        fab_en_r[k] <= pwdata[FAB_EN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd) begin
      prdata <= '0;
      if (paddr == ADDR_CTRL) begin
        prdata[CTRL_TAG_ADMIN] <= ctrl_tag_admin_r;
        prdata[CTRL_AUTH_DIS] <= ctrl_auth_dis_r;
        prdata[CTRL_VF_CAP] <= ctrl_vf_cap_r;
      end else if (paddr == ADDR_VFID) begin
        prdata[VFID_W-1:0] <= def_vfid_r;
      end else if (paddr == ADDR_STAT) begin
        prdata[3:0] <= st_r;
        for (int k = 0; k < NUM_VF; k++) begin
          prdata[8+3*k +: 3] <= fst_r[k];
        end
      end else begin
        for (int k = 0; k < NUM_VF; k++) begin
          if (paddr == ADDR_FAB0 + 8'(4 * k)) begin
            prdata[VFID_W-1:0] <= fab_vfid_r[k];
            prdata[FAB_EN_BIT] <= fab_en_r[k];
          end
        end
      end
    end
  end

  // a bridge peer must have announced tagging first
  assign vf_ok = ctrl_vf_cap_r && (!evt.bridge_peer || evt.bridge_vf_flag); // R5
  assign neg_vf = vf_ok && evt.peer_vf_sup; // R4
  assign auth_needed = (!ctrl_auth_dis_r) || evt.peer_auth_req; // R8 R20

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      port_init_start_state: st_nxt = link_param_exchange_state;
      link_param_exchange_state:
        if (evt.elp_done) st_nxt = esc_exchange_state;
      esc_exchange_state:
        if (evt.esc_done) begin
          if (!neg_vf) st_nxt = untagged_continuation_state; // R6
          else if (auth_needed) st_nxt = vf_authentication_state; // R8
          else st_nxt = evfp_processing_state; // R8
        end
      vf_authentication_state:
        if (evt.auth_fail) st_nxt = auth_failure_state; // R10
        else if (evt.auth_ok) st_nxt = evfp_processing_state; // R10
      evfp_processing_state:
        if (evt.evfp_done) begin
          if (evt.evfp_tag) st_nxt = tagging_active_state; // R12
          else if (evt.peer_vfid == def_vfid_r) begin
            st_nxt = untagged_continuation_state; // R11
          end else st_nxt = isolated_state; // R11
        end
      untagged_continuation_state:
        if (evt.untag_done) st_nxt = untagged_eport_operating_state;
      default: st_nxt = st_r;
    endcase
    // link reset is ignored; only link init restarts
    if (evt.link_init) st_nxt = port_init_start_state; // R7
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= port_init_start_state;
    else st_r <= st_nxt;
  end

  // per-fabric sub-machines, each with its own state
  for (genvar k = 0; k < NUM_VF; k++) begin : g_fab
    always_ff @(posedge pclk or negedge presetn) begin // R23
      if (!presetn) begin
        fst_r[k] <= fab_idle_state;
      end else if (evt.link_init || st_r != tagging_active_state) begin
        fst_r[k] <= fab_idle_state; // R7
      end else begin
        unique case (fst_r[k])
          fab_idle_state:
            if (fab_en_r[k]) fst_r[k] <= per_fabric_link_param_state; // R12
          per_fabric_link_param_state:
            if (fevt.force_iso[k]) begin
              fst_r[k] <= per_fabric_logical_isolation_state; // R18
            end else if (fevt.elp_done[k]) begin
              fst_r[k] <= per_fabric_security_check_state; // R14
            end
          per_fabric_security_check_state:
            if (fevt.sec_fail[k] || fevt.force_iso[k]) begin
              fst_r[k] <= per_fabric_logical_isolation_state; // R16
            end else if (fevt.sec_ok[k]) begin
              fst_r[k] <= per_fabric_operating_state; // R16
            end
          per_fabric_operating_state:
            if (fevt.force_iso[k]) begin
              fst_r[k] <= per_fabric_logical_isolation_state; // R18
            end
          per_fabric_logical_isolation_state:
            if (fevt.elp_seen[k]) begin
              fst_r[k] <= per_fabric_link_param_state; // R19
            end
        endcase
      end
    end
    assign fab_tag_en[k] = fst_r[k] != fab_idle_state; // R13 R17
    assign fab_send_elp[k] = fst_r[k] == per_fabric_link_param_state; // R13
    assign fab_send_rjt[k] = fst_r[k] == per_fabric_security_check_state
                             && fevt.efp_rx[k]; // R15
    assign fab_join_cfg[k] = fst_r[k] == per_fabric_operating_state; // R17
    assign fab_class_n_en[k] = fst_r[k] == per_fabric_operating_state; // R18
  end

  // untagged frames fall into the default fabric
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_class_vfid <= DEF_VFID_RST;
    else rx_class_vfid <= rx_tagged ? rx_vfid : def_vfid_r; // R22
  end

  always_comb begin
    act.esc_adv_vf = (st_r == esc_exchange_state) && vf_ok; // R4 R5
    act.use_default_name = (st_r == link_param_exchange_state) ||
                           (st_r == untagged_eport_operating_state); // R1 R2
    act.name_vfid = def_vfid_r; // R1 R2
    act.send_rjt = (st_r == vf_authentication_state) && evt.evfp_rx; // R9
    act.rjt_reason = RJT_LOGICAL_BUSY; // R9
    act.rjt_expl = EXPL_SEC_CHECKS; // R9
    act.tag_rx_en = (st_r == tagging_active_state) && ctrl_tag_admin_r;
  end

  assign main_state = st_r;

  property p_linit;
    @(posedge pclk) disable iff (!presetn)
      evt.link_init |=> st_r == port_init_start_state;
  endproperty
  a_linit: assert property (p_linit) else $error("link init no restart"); // R7

  property p_auth;
    @(posedge pclk) disable iff (!presetn)
      st_r == vf_authentication_state && evt.auth_fail && !evt.link_init
      |=> st_r == auth_failure_state;
  endproperty
  a_auth: assert property (p_auth) else $error("auth fail path"); // R10

  property p_rjt;
    @(posedge pclk) disable iff (!presetn)
      act.send_rjt |-> act.rjt_reason == RJT_LOGICAL_BUSY;
  endproperty
  a_rjt: assert property (p_rjt) else $error("bad reject reason"); // R9

  property p_iso;
    @(posedge pclk) disable iff (!presetn)
      st_r == evfp_processing_state && evt.evfp_done && !evt.evfp_tag &&
      !evt.link_init && evt.peer_vfid != def_vfid_r |=> st_r == isolated_state;
  endproperty
  a_iso: assert property (p_iso) else $error("mismatch not isolated"); // R11

  // fabric 0 stands for every slot; the slots share one generate body
  logic fab_live;
  assign fab_live = st_r == tagging_active_state && !evt.link_init;

  property p_untag;
    @(posedge pclk) disable iff (!presetn)
      st_r == esc_exchange_state && evt.esc_done && !neg_vf &&
      !evt.link_init |=> st_r == untagged_continuation_state;
  endproperty
  a_untag: assert property (p_untag) else $error("no untagged path"); // R6

  property p_evfp;
    @(posedge pclk) disable iff (!presetn)
      st_r == esc_exchange_state && evt.esc_done && neg_vf && !auth_needed &&
      !evt.link_init |=> st_r == evfp_processing_state;
  endproperty
  a_evfp: assert property (p_evfp) else $error("no direct evfp"); // R8

  property p_authgo;
    @(posedge pclk) disable iff (!presetn)
      st_r == esc_exchange_state && evt.esc_done && neg_vf && auth_needed &&
      !evt.link_init |=> st_r == vf_authentication_state;
  endproperty
  a_authgo: assert property (p_authgo) else $error("auth skipped"); // R8

  property p_authok;
    @(posedge pclk) disable iff (!presetn)
      st_r == vf_authentication_state && evt.auth_ok && !evt.auth_fail &&
      !evt.link_init |=> st_r == evfp_processing_state;
  endproperty
  a_authok: assert property (p_authok) else $error("auth ok path"); // R10

  property p_same;
    @(posedge pclk) disable iff (!presetn)
      st_r == evfp_processing_state && evt.evfp_done && !evt.evfp_tag &&
      !evt.link_init && evt.peer_vfid == def_vfid_r
      |=> st_r == untagged_continuation_state;
  endproperty
  a_same: assert property (p_same) else $error("equal ids not untagged"); // R11

  property p_tag;
    @(posedge pclk) disable iff (!presetn)
      st_r == evfp_processing_state && evt.evfp_done && evt.evfp_tag &&
      !evt.link_init |=> st_r == tagging_active_state;
  endproperty
  a_tag: assert property (p_tag) else $error("tagging not entered"); // R12

  property p_lreset;
    @(posedge pclk) disable iff (!presetn)
      fab_live && evt.link_reset |=> st_r == tagging_active_state;
  endproperty
  a_lreset: assert property (p_lreset) else $error("link reset hit"); // R7

  property p_elp;
    @(posedge pclk) disable iff (!presetn)
      fab_live && fst_r[0] == per_fabric_link_param_state &&
      fevt.elp_done[0] && !fevt.force_iso[0]
      |=> fst_r[0] == per_fabric_security_check_state;
  endproperty
  a_elp: assert property (p_elp) else $error("elp not done"); // R14

  property p_secfail;
    @(posedge pclk) disable iff (!presetn)
      fab_live && fst_r[0] == per_fabric_security_check_state &&
      fevt.sec_fail[0] |=> fst_r[0] == per_fabric_logical_isolation_state;
  endproperty
  a_secfail: assert property (p_secfail) else $error("check fail path"); // R16

  property p_secok;
    @(posedge pclk) disable iff (!presetn)
      fab_live && fst_r[0] == per_fabric_security_check_state &&
      fevt.sec_ok[0] && !fevt.sec_fail[0] && !fevt.force_iso[0]
      |=> fst_r[0] == per_fabric_operating_state;
  endproperty
  a_secok: assert property (p_secok) else $error("check ok path"); // R16

  property p_relp;
    @(posedge pclk) disable iff (!presetn)
      fab_live && fst_r[0] == per_fabric_logical_isolation_state &&
      fevt.elp_seen[0] |=> fst_r[0] == per_fabric_link_param_state;
  endproperty
  a_relp: assert property (p_relp) else $error("no return to elp"); // R19

  property p_indep;
    @(posedge pclk) disable iff (!presetn)
      fab_live && fst_r[1] == per_fabric_operating_state &&
      !fevt.force_iso[1] |=> fst_r[1] == per_fabric_operating_state;
  endproperty
  a_indep: assert property (p_indep) else $error("fabric disturbed"); // R23

  property p_untagrx;
    @(posedge pclk) disable iff (!presetn)
      !rx_tagged |=> rx_class_vfid == $past(def_vfid_r);
  endproperty
  a_untagrx: assert property (p_untagrx) else $error("untagged class"); // R22

  property p_tagrx;
    @(posedge pclk) disable iff (!presetn)
      rx_tagged |=> rx_class_vfid == $past(rx_vfid);
  endproperty
  a_tagrx: assert property (p_tagrx) else $error("tagged class"); // R21

  property p_expl;
    @(posedge pclk) disable iff (!presetn)
      act.send_rjt |-> act.rjt_expl == EXPL_SEC_CHECKS;
  endproperty
  a_expl: assert property (p_expl) else $error("bad reject explanation"); // R9

  property p_esc;
    @(posedge pclk) disable iff (!presetn)
      act.esc_adv_vf |-> ctrl_vf_cap_r &&
      (!evt.bridge_peer || evt.bridge_vf_flag);
  endproperty
  a_esc: assert property (p_esc) else $error("bridge advertised"); // R5

  property p_frjt;
    @(posedge pclk) disable iff (!presetn)
      fab_send_rjt[0] |-> fevt.efp_rx[0] &&
      fst_r[0] == per_fabric_security_check_state;
  endproperty
  a_frjt: assert property (p_frjt) else $error("stray efp reject"); // R15

  property p_cls;
    @(posedge pclk) disable iff (!presetn)
      fst_r[0] == per_fabric_logical_isolation_state |-> !fab_class_n_en[0];
  endproperty
  a_cls: assert property (p_cls) else $error("traffic while isolated"); // R18

  property p_ftag;
    @(posedge pclk) disable iff (!presetn)
      fst_r[0] == per_fabric_link_param_state |->
      fab_tag_en[0] && fab_send_elp[0];
  endproperty
  a_ftag: assert property (p_ftag) else $error("elp untagged"); // R13

  property p_name;
    @(posedge pclk) disable iff (!presetn)
      st_r == link_param_exchange_state |->
      act.use_default_name && act.name_vfid == def_vfid_r;
  endproperty
  a_name: assert property (p_name) else $error("wrong element name"); // R1
endmodule
`default_nettype wire

/* verif/tb.sv */
// bench for the virtual fabric port init machine and its peer model
// assumes one 200 MHz clock and configuration over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vpi_pkg::*;
  localparam vpi_fab_type FI = fab_idle_state;
  localparam vpi_fab_type FS = per_fabric_security_check_state;
  localparam vpi_fab_type FO = per_fabric_operating_state;
  localparam vpi_fab_type FX = per_fabric_logical_isolation_state;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rx_tagged = 1'b0;
  logic smp = 1'b0;
  logic pready, pslverr;
  logic [2:0] sel = 3'h0;
  logic [7:0] paddr = 8'h0;
  logic [11:0] rx_vfid = 12'h0;
  logic [11:0] rx_class_vfid, dv;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] cfg = 32'h0;
  logic [31:0] rs = 32'h61;
  logic [31:0] prdata, obs;
  logic [3:0] fab_send_elp, fab_tag_en, fab_send_rjt, fab_join_cfg;
  logic [3:0] fab_class_n_en;
  vpi_evt_type evt, evt_m;
  vpi_evt_type evt_tb = '0;
  vpi_fab_evt_type fevt, fevt_m;
  vpi_fab_evt_type fevt_tb = '0;
  vpi_act_type act;
  vpi_main_type main_state;
  vpi_main_type stop = link_param_exchange_state;
  logic [31:0] q[$];
  int fails = 0;
  int checked = 0;
  always #2.5 pclk = ~pclk;
  assign evt = evt_m | evt_tb;
  assign fevt = fevt_m | fevt_tb;
  vpi_port_init i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .evt, .fevt, .rx_vfid, .rx_tagged,
    .rx_class_vfid, .act, .fab_send_elp, .fab_tag_en, .fab_send_rjt,
    .fab_join_cfg, .fab_class_n_en, .main_state);
  vpi_peer_model i_peer (.pclk, .presetn, .main_state, .stop_state(stop),
    .fab_send_elp, .cfg, .evt(evt_m), .fevt(fevt_m));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] st(vpi_main_type m, logic [11:0] f);
    return {12'h0, f, 4'h0, m};
  endfunction
  // the monitor takes the oldest note when a sample is flagged
  task automatic look(input logic [2:0] s, input logic [31:0] e);
    q.push_back(e);
    sel <= s;
    smp <= 1'b1;
    @(posedge pclk);
    smp <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    look(3'h0, e);
  endtask
  task automatic wm(input vpi_main_type m);
    do @(posedge pclk); while (main_state !== m);
  endtask
  task automatic lin(input vpi_main_type s);
    evt_tb.link_init <= 1'b1;
    stop <= s;
    @(posedge pclk);
    evt_tb.link_init <= 1'b0;
    wm(s);
  endtask
  task automatic fw();
    repeat (2) @(posedge pclk);
    while (fab_send_elp !== 4'h0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  always_comb begin
    case (sel)
      3'h0: obs = prdata;
      3'h1: obs = {19'h0, act.use_default_name, act.name_vfid};
      3'h2: obs = {23'h0, act.send_rjt, act.rjt_reason, act.rjt_expl};
      3'h3: obs = {30'h0, act.tag_rx_en, act.esc_adv_vf};
      3'h4: obs = {16'h0, fab_send_rjt, fab_tag_en, fab_join_cfg, fab_class_n_en};
      default: obs = {20'h0, rx_class_vfid};
    endcase
  end
  always @(posedge pclk) if (smp === 1'b1) chk(obs, q.pop_front());
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wm(link_param_exchange_state);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_VFID, {20'h0, DEF_VFID_RST});
    rd(ADDR_STAT, st(link_param_exchange_state, 12'h0));
    dv = 12'(rnd());
    apb(1'b1, ADDR_VFID, {20'h0, dv});
    apb(1'b1, 8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    rd(ADDR_VFID, {20'h0, dv});
    for (int k = 0; k < 4; k++) apb(1'b1, ADDR_FAB0 + 8'(4 * k),
      {19'h0, 1'(k < 3), 12'(rnd())});
    look(3'h1, {19'h0, 1'b1, dv});
    $display("test 1 done");
    apb(1'b1, ADDR_CTRL, 32'h5);
    cfg <= 32'h9;
    stop <= esc_exchange_state;
    wm(esc_exchange_state);
    look(3'h3, 32'h0);
    stop <= untagged_eport_operating_state;
    wm(untagged_eport_operating_state);
    rd(ADDR_STAT, st(untagged_eport_operating_state, 12'h0));
    look(3'h1, {19'h0, 1'b1, dv});
    rx_vfid <= 12'(rnd());
    @(posedge pclk);
    look(3'h5, {20'h0, dv});
    rx_tagged <= 1'b1;
    @(posedge pclk);
    look(3'h5, {20'h0, rx_vfid});
    $display("test 2 done");
    cfg <= {16'h0, 4'(rnd() % 4), 12'h019};
    lin(esc_exchange_state);
    look(3'h3, 32'h1);
    stop <= vf_authentication_state;
    wm(vf_authentication_state);
    rd(ADDR_STAT, st(vf_authentication_state, 12'h0));
    evt_tb.evfp_rx <= 1'b1;
    look(3'h2, {23'h0, 1'b1, RJT_LOGICAL_BUSY, EXPL_SEC_CHECKS});
    evt_tb.evfp_rx <= 1'b0;
    cfg[2] <= 1'b1;
    stop <= port_init_start_state;
    wm(auth_failure_state);
    rd(ADDR_STAT, st(auth_failure_state, 12'h0));
    $display("test 3 done");
    // a failing peer check would divert to the failure state if auth ran
    apb(1'b1, ADDR_CTRL, 32'h7);
    for (int i = 0; i < 2; i++) begin
      cfg <= {4'h0, dv ^ 12'(i), 16'h001d};
      lin(i ? isolated_state : untagged_continuation_state);
      rd(ADDR_STAT, st(i ? isolated_state : untagged_continuation_state,
        12'h0));
    end
    $display("test 4 done");
    apb(1'b1, ADDR_CTRL, 32'h5);
    cfg <= {4'h0, dv, 4'(rnd() % 4), 12'h479};
    lin(tagging_active_state);
    stop <= port_init_start_state;
    fw();
    rd(ADDR_STAT, st(tagging_active_state, {FI, FS, FS, FS}));
    look(3'h3, 32'h2);
    fevt_tb.efp_rx <= 4'h2;
    look(3'h4, 32'h2700);
    fevt_tb.efp_rx <= 4'h0;
    cfg[6] <= 1'b0;
    while (fab_join_cfg[1:0] !== 2'b11) @(posedge pclk);
    rd(ADDR_STAT, st(tagging_active_state, {FI, FX, FO, FO}));
    cfg[6] <= 1'b1;
    fevt_tb.force_iso <= 4'h1;
    fevt_tb.elp_seen <= 4'h4;
    @(posedge pclk);
    fevt_tb <= '0;
    fw();
    rd(ADDR_STAT, st(tagging_active_state, {FI, FS, FO, FX}));
    evt_tb.link_reset <= 1'b1;
    @(posedge pclk);
    evt_tb.link_reset <= 1'b0;
    rd(ADDR_STAT, st(tagging_active_state, {FI, FS, FO, FX}));
    lin(link_param_exchange_state);
    rd(ADDR_STAT, st(link_param_exchange_state, 12'h0));
    $display("test 5 done");
    test_done();
  end
endmodule
`default_nettype wire

/* verif/vpi_peer_model.sv */
// peer switch port model: answers each bring-up step after a delay
// assumes the bench sets cfg while the main machine is held at stop_state
`timescale 1ns/1ps
`default_nettype none
module vpi_peer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire vpi_pkg::vpi_main_type main_state,
  input wire vpi_pkg::vpi_main_type stop_state,
  input wire logic [3:0] fab_send_elp,
  input wire logic [31:0] cfg,
  output vpi_pkg::vpi_evt_type evt,
  output vpi_pkg::vpi_fab_evt_type fevt
);
  import vpi_pkg::*;
  logic [3:0] cnt_r;
  logic [3:0] pend_r;
  logic fire;
  // one delay field gives prompt and slow answers alike
  assign fire = cnt_r >= cfg[15:12] && main_state != stop_state;
  always_comb begin
    evt = '0;
    fevt = '0;
    evt.peer_vf_sup = cfg[0];
    evt.peer_auth_req = cfg[1];
    evt.bridge_peer = cfg[3];
    evt.bridge_vf_flag = cfg[4];
    evt.evfp_tag = cfg[5];
    evt.peer_vfid = cfg[27:16];
    if (fire) begin
      case (main_state)
        link_param_exchange_state: evt.elp_done = 1'b1;
        esc_exchange_state: evt.esc_done = 1'b1;
        vf_authentication_state: begin
          evt.auth_ok = !cfg[2];
          evt.auth_fail = cfg[2];
        end
        evfp_processing_state: evt.evfp_done = 1'b1;
        untagged_continuation_state: evt.untag_done = 1'b1;
        tagging_active_state: begin
          fevt.elp_done = fab_send_elp;
          if (!cfg[6]) begin
            fevt.sec_ok = pend_r & ~cfg[11:8];
            fevt.sec_fail = pend_r & cfg[11:8];
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      pend_r <= 4'h0;
    end else begin
      cnt_r <= fire ? 4'h0 : cnt_r + 4'h1;
      pend_r <= (pend_r & ~(fevt.sec_ok | fevt.sec_fail)) | fevt.elp_done;
    end
  end
endmodule
`default_nettype wire
